//--- hdl/mcs_top.sv
// Purpose: Modem control scanner for sixteen lines behind AXI4-Lite
// Assumes: Single 40 MHz clock, synchronous active-low reset
// Notes: Ring counter steps one phase per clock while scanning
//
// Function
// - Host writes line number into 4-bit counter; per-line accesses use it.
// - Sixteen enable flops; write strobes only the selected line's flop.
// - Terminal ready, request send, new sync held per line, written likewise.
// - Host reads set ready, clear send, carrier, ring of selected line.
// - Async lines use secondary transmit/receive for new sync/set ready.
// - Counter loads from host write and wraps when stepped by scanner.
// - Sixteen 4-bit scan entries; transitions found by comparing old, new.
// - Self-clocking 4-bit ring counter starts when scan enable is set.
// - Ring step one increments the line counter to next line.
// - Ring step two copies the addressed entry into hold register.
// - Ring step three writes selected modem's status into the entry.
// - Step four: change on enabled line sets done, stops ring.
// - Done with interrupt enable set raises host interrupt request.
// - Scanning stays halted while done; host clears done to resume.
`timescale 1ns/1ps
`include "mcs_params.svh"
module mcs_top #(
  parameter int LINES = 16,
  parameter logic [15:0] ASYNC_RESET = 16'h0000
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Modem status inputs, one bit per line
  input wire logic [15:0] set_ready_in,
  input wire logic [15:0] clear_send_in,
  input wire logic [15:0] carrier_on_in,
  input wire logic [15:0] ring_in,
  input wire logic [15:0] secondary_receive_in,
  // Modem control outputs
  output mcs_pkg::mcs_ctl_type modem_ctl,
  // Interrupt request
  output logic irq
);
  import mcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  logic [79:0] raw_in;
  logic [79:0] sync_in;
  logic [15:0] dsr_s;
  logic [15:0] cs_s;
  logic [15:0] co_s;
  logic [15:0] ri_s;
  logic [15:0] srx_s;

  assign raw_in = {secondary_receive_in, ring_in, carrier_on_in,
                   clear_send_in, set_ready_in};
  assign {srx_s, ri_s, co_s, cs_s, dsr_s} = sync_in;

  mcs_sync #(.W(80)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(raw_in),
    .q(sync_in)
  );

  ////////////////////////////////////////////////////////////////////////
  // State

  logic [3:0] line_q;
  logic scan_en_q;
  logic int_en_q;
  logic done_q;
  logic [LINES-1:0] enable_q;
  logic [LINES-1:0] term_rdy_q;
  logic [LINES-1:0] req_send_q;
  logic [LINES-1:0] new_sync_q;
  logic [15:0] async_q;
  logic [3:0] ring_q;
  mcs_stat_type scan_mem [LINES];
  mcs_stat_type hold_q;
  mcs_stat_type cur_stat;
  logic change;

  // Current status of the selected line, async lines swap in sec receive
  always_comb begin
    cur_stat.ring = ri_s[line_q];
    cur_stat.carrier_on = co_s[line_q];
    cur_stat.clear_send = cs_s[line_q];
    cur_stat.set_ready = async_q[line_q] ? srx_s[line_q]
                                         : dsr_s[line_q];
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  logic aw_have_q;
  logic w_have_q;
  logic [`MCS_ADDR_BITS-1:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_go;
  logic wr_ctrl;
  logic wr_line;
  logic wr_async;

  assign wr_go = aw_have_q && w_have_q && !bvalid;
  assign wr_ctrl = wr_go && (waddr_q == `MCS_OFS_CTRL) && wstrb_q[0];
  assign wr_line = wr_go && (waddr_q == `MCS_OFS_LINE) && wstrb_q[0];
  assign wr_async = wr_go && (waddr_q == `MCS_OFS_ASYNC);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awready <= 1'b0;
      waddr_q <= '0;
    end else if (awvalid && awready) begin
      aw_have_q <= 1'b1;
      awready <= 1'b0;
      waddr_q <= awaddr[`MCS_ADDR_BITS-1:0];
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
    end else if (!aw_have_q && !bvalid) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wready <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (wvalid && wready) begin
      w_have_q <= 1'b1;
      wready <= 1'b0;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (wr_go) begin
      w_have_q <= 1'b0;
    end else if (!w_have_q && !bvalid) begin
      wready <= 1'b1;
    end
  end

  // Upper address bits are ignored, so the map aliases every 16 bytes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `MCS_RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      if (waddr_q == `MCS_OFS_CTRL || waddr_q == `MCS_OFS_LINE ||
          waddr_q == `MCS_OFS_ASYNC) begin
        bresp <= `MCS_RESP_OKAY;
      end else begin
        bresp <= `MCS_RESP_SLVERR;
      end
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  logic [`MCS_ADDR_BITS-1:0] raddr;
  logic [31:0] rmux;
  logic rhit;

  assign raddr = araddr[`MCS_ADDR_BITS-1:0];

  always_comb begin
    rmux = 32'h0000_0000;
    rhit = 1'b1;
    case (raddr)
      `MCS_OFS_CTRL: begin
        rmux[`MCS_CTRL_LINE_HI:`MCS_CTRL_LINE_LO] = line_q;
        rmux[`MCS_CTRL_SCAN_EN] = scan_en_q;
        rmux[`MCS_CTRL_INT_EN] = int_en_q;
        rmux[`MCS_CTRL_DONE] = done_q;
      end
      `MCS_OFS_LINE: begin
        rmux[`MCS_LINE_ENABLE] = enable_q[line_q];
        rmux[`MCS_LINE_TERM_RDY] = term_rdy_q[line_q];
        rmux[`MCS_LINE_REQ_SEND] = req_send_q[line_q];
        rmux[`MCS_LINE_NEW_SYNC] = new_sync_q[line_q];
        rmux[`MCS_LINE_STAT_HI:`MCS_LINE_STAT_LO] = cur_stat;
      end
      `MCS_OFS_ASYNC: begin
        rmux[15:0] = async_q;
      end
      default: begin
        rhit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `MCS_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rmux;
      rresp <= rhit ? `MCS_RESP_OKAY : `MCS_RESP_SLVERR;
    end else if (rvalid) begin
      if (rready) begin
        rvalid <= 1'b0;
      end
    end else begin
      arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register and line counter

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_en_q <= 1'b0;
      int_en_q <= 1'b0;
    end else if (wr_ctrl) begin
      scan_en_q <= wdata_q[`MCS_CTRL_SCAN_EN];
      int_en_q <= wdata_q[`MCS_CTRL_INT_EN];
    end
  end

  // A host load beats a scan step landing in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_q <= 4'h0;
    end else if (wr_ctrl) begin
      line_q <= wdata_q[`MCS_CTRL_LINE_HI:`MCS_CTRL_LINE_LO];
    end else if (ring_q[0]) begin
      line_q <= line_q + 4'h1;
    end
  end

  // Writing zero to the done bit clears it; a fresh detection wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
    end else if (change) begin
      done_q <= 1'b1;
    end else if (wr_ctrl && !wdata_q[`MCS_CTRL_DONE]) begin
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= done_q && int_en_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-line settings

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= '0;
      term_rdy_q <= '0;
      req_send_q <= '0;
      new_sync_q <= '0;
    end else if (wr_line) begin
      enable_q[line_q] <= wdata_q[`MCS_LINE_ENABLE];
      term_rdy_q[line_q] <= wdata_q[`MCS_LINE_TERM_RDY];
      req_send_q[line_q] <= wdata_q[`MCS_LINE_REQ_SEND];
      new_sync_q[line_q] <= wdata_q[`MCS_LINE_NEW_SYNC];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      async_q <= ASYNC_RESET;
    end else if (wr_async) begin
      if (wstrb_q[0]) begin
        async_q[7:0] <= wdata_q[7:0];
      end
      if (wstrb_q[1]) begin
        async_q[15:8] <= wdata_q[15:8];
      end
    end
  end

  // Registered so every modem output comes straight from a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      modem_ctl <= '0;
    end else begin
      modem_ctl.term_ready <= term_rdy_q;
      modem_ctl.request_send <= req_send_q;
      modem_ctl.new_sync <= new_sync_q & ~async_q;
      modem_ctl.secondary_transmit <= new_sync_q & async_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ring counter and scan memory

  assign change = ring_q[3] && (scan_mem[line_q] != hold_q) &&
                  enable_q[line_q];

  // Clearing scan enable lets the current line finish its four steps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ring_q <= `MCS_RING_IDLE;
    end else if (ring_q == `MCS_RING_IDLE) begin
      if (scan_en_q && !done_q) begin
        ring_q <= `MCS_RING_STEP1;
      end
    end else if (ring_q[3]) begin
      if (change || done_q || !scan_en_q) begin
        ring_q <= `MCS_RING_IDLE;
      end else begin
        ring_q <= `MCS_RING_STEP1;
      end
    end else begin
      ring_q <= {ring_q[2:0], 1'b0};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_q <= '0;
    end else if (ring_q[1]) begin
      hold_q <= scan_mem[line_q];
    end
  end

  // Entry is written before compare, so a restart moves on to next line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < LINES; i++) begin
        scan_mem[i] <= '0;
      end
    end else if (ring_q[2]) begin
      scan_mem[line_q] <= cur_stat;
    end
  end

endmodule

//--- hdl/mcs_params.svh
// Purpose: Offsets, field positions and reset values of the modem scanner
// Assumes: Included by bare name wherever these constants are needed
// Notes: Definitions only
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH

// Register byte offsets
`define MCS_OFS_CTRL 4'h0
`define MCS_OFS_LINE 4'h4
`define MCS_OFS_ASYNC 4'h8
`define MCS_ADDR_BITS 4

// Scanner control register fields
`define MCS_CTRL_LINE_LO 0
`define MCS_CTRL_LINE_HI 3
`define MCS_CTRL_SCAN_EN 5
`define MCS_CTRL_INT_EN 6
`define MCS_CTRL_DONE 7

// Line setting register fields
`define MCS_LINE_ENABLE 0
`define MCS_LINE_TERM_RDY 1
`define MCS_LINE_REQ_SEND 2
`define MCS_LINE_NEW_SYNC 3
`define MCS_LINE_STAT_LO 8
`define MCS_LINE_STAT_HI 11

// Ring counter codes
`define MCS_RING_IDLE 4'h0
`define MCS_RING_STEP1 4'h1

// Bus responses
`define MCS_RESP_OKAY 2'h0
`define MCS_RESP_SLVERR 2'h2

`endif

//--- hdl/mcs_pkg.sv
// Purpose: Types shared by the modem scanner files
// Assumes: Nothing beyond the params header
// Notes: Status nibble order matches the scan memory entry layout
package mcs_pkg;

  // One line's modem status, as held in one scan memory entry
  typedef struct packed {
    logic ring;
    logic carrier_on;
    logic clear_send;
    logic set_ready;
  } mcs_stat_type;

  // Modem control outputs for all sixteen lines
  typedef struct packed {
    logic [15:0] term_ready;
    logic [15:0] request_send;
    logic [15:0] new_sync;
    logic [15:0] secondary_transmit;
  } mcs_ctl_type;

endpackage

//--- hdl/mcs_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs are asynchronous to aclk
// Notes: Output changes only once stages two and three agree
`timescale 1ns/1ps
module mcs_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          q[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          q[i] <= s3_q[i];
        end
      end
    end
  endgenerate

endmodule

//--- test/mcs_modem_model.sv
// Purpose: Status lines of sixteen modems facing the scanner
// Assumes: Levels change only when the bench calls put
// Notes: Lines never touched stay low, as an idle modem leaves them
`timescale 1ns/1ps
module mcs_modem_model (
  // Status lines toward the scanner
  output logic [15:0] set_ready,
  output logic [15:0] clear_send,
  output logic [15:0] carrier_on,
  output logic [15:0] ring,
  output logic [15:0] secondary_receive
);
  import mcs_pkg::*;
  initial begin
    {set_ready, clear_send, carrier_on, ring, secondary_receive} = 80'h0;
  end
  // One modem changes its status levels
  task automatic put(input int l, input mcs_stat_type s, input logic rx);
    set_ready[l] <= s.set_ready;
    clear_send[l] <= s.clear_send;
    carrier_on[l] <= s.carrier_on;
    ring[l] <= s.ring;
    secondary_receive[l] <= rx;
  endtask
endmodule

//--- test/mcs_top_properties.sv
// Purpose: Port-level properties of the modem scanner
// Assumes: One aclk domain, synchronous active-low aresetn
// Notes: Bound into every mcs_top instance
`timescale 1ns/1ps
`include "mcs_params.svh"
module mcs_top_properties (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // Modem side
  input mcs_pkg::mcs_ctl_type modem_ctl,
  input wire logic irq
);
  import mcs_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////////////////////////
  chk_write_answer: assert property (
    awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
    else $error("write answer missing");
  chk_read_answer: assert property (
    arvalid && arready |=> rvalid) else $error("read answer missing");
  chk_bresp_stands: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  chk_rdata_stands: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped");
  chk_write_single: assert property (
    bvalid |-> !awready && !wready) else $error("write overlap");
  chk_read_single: assert property (
    rvalid |-> !arready) else $error("read overlap");
  chk_bresp_legal: assert property (
    bvalid |-> bresp inside {`MCS_RESP_OKAY, `MCS_RESP_SLVERR})
    else $error("bad write response");
  chk_refused_zero: assert property (
    rvalid && rresp == `MCS_RESP_SLVERR |-> rdata == 32'h0)
    else $error("refused read not zero");
  chk_sync_swap: assert property (
    (modem_ctl.new_sync & modem_ctl.secondary_transmit) == 16'h0)
    else $error("sync and secondary both driven");
  chk_reset_quiet: assert property (
    $rose(aresetn) |-> !irq && !bvalid && !rvalid)
    else $error("outputs busy after reset");
  cover property ($rose(irq));
  cover property (bvalid && bresp == `MCS_RESP_SLVERR);
  cover property (rvalid && rresp == `MCS_RESP_OKAY);
endmodule
bind mcs_top mcs_top_properties u_props (.aclk, .aresetn, .awvalid,
  .awready, .wvalid, .wready, .bvalid, .bready, .bresp, .arvalid,
  .arready, .rvalid, .rready, .rdata, .rresp, .modem_ctl, .irq);

//--- test/mcs_top_tb.sv
// Purpose: Self-checking bench for the modem control scanner
// Assumes: AXI4-Lite master tasks, modem status from the partner model
// Notes: Scan halts are found by polling the control register
`timescale 1ns/1ps
`include "mcs_params.svh"
module mcs_top_tb;
  import mcs_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, gresp;
  logic [31:0] got;
  logic [15:0] set_ready_in, clear_send_in, carrier_on_in, ring_in;
  logic [15:0] secondary_receive_in;
  mcs_ctl_type modem_ctl;
  int err_count = 0;
  int comparisons = 0;
  always #12.5 aclk = ~aclk;
  mcs_top DUT (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(arprot), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .set_ready_in(set_ready_in),
    .clear_send_in(clear_send_in), .carrier_on_in(carrier_on_in),
    .ring_in(ring_in), .secondary_receive_in(secondary_receive_in),
    .modem_ctl(modem_ctl), .irq(irq));
  mcs_modem_model MDL (.set_ready(set_ready_in), .clear_send(clear_send_in),
    .carrier_on(carrier_on_in), .ring(ring_in),
    .secondary_receive(secondary_receive_in));
  //////////////////////////////
  task automatic cmp(input logic [31:0] g, e, input string m);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic results;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, d, input logic [1:0] e);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 40);
    bready <= 1'h0;
    cmp({31'h0, bvalid}, 32'h1, "bvalid");
    cmp({30'h0, bresp}, {30'h0, e}, "bresp");
    @(posedge aclk);
  endtask
  task automatic rd(input logic [31:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 40);
    cmp({31'h0, rvalid}, 32'h1, "rvalid");
    got = rdata;
    gresp = rresp;
    rready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic chk(input logic [31:0] a, e, input logic [1:0] er);
    rd(a);
    cmp(got, e, "rdata");
    cmp({30'h0, gresp}, {30'h0, er}, "rresp");
  endtask
  // Reads control until done shows, then checks the halt state
  task automatic poll(input logic [31:0] e);
    int n;
    n = 0;
    do begin
      rd(`MCS_OFS_CTRL);
      n++;
    end while (got[7] !== 1'h1 && n < 60);
    cmp(got, e, "halt state");
  endtask
  //////////////////////////////
  task automatic s_regs;
    chk(`MCS_OFS_CTRL, 32'h0, `MCS_RESP_OKAY);
    chk(`MCS_OFS_ASYNC, 32'h0, `MCS_RESP_OKAY);
    wr(32'hc, 32'h1, `MCS_RESP_SLVERR);
    chk(32'hc, 32'h0, `MCS_RESP_SLVERR);
    // Done is read-only to a one
    wr(`MCS_OFS_CTRL, 32'h8f, `MCS_RESP_OKAY);
    chk(`MCS_OFS_CTRL, 32'hf, `MCS_RESP_OKAY);
  endtask
  task automatic s_lines;
    for (int i = 0; i < 16; i++) begin
      wr(`MCS_OFS_CTRL, 32'(i), `MCS_RESP_OKAY);
      wr(`MCS_OFS_LINE, 32'(i), `MCS_RESP_OKAY);
    end
    chk(`MCS_OFS_LINE, 32'hf, `MCS_RESP_OKAY);
    cmp({16'h0, modem_ctl.term_ready}, 32'hcccc, "ready");
    cmp({16'h0, modem_ctl.request_send}, 32'hf0f0, "send");
    cmp({16'h0, modem_ctl.new_sync}, 32'hff00, "sync");
    wr(`MCS_OFS_ASYNC, 32'hf00, `MCS_RESP_OKAY);
    chk(`MCS_OFS_ASYNC, 32'hf00, `MCS_RESP_OKAY);
    cmp({16'h0, modem_ctl.new_sync}, 32'hf000, "sync async");
    cmp({16'h0, modem_ctl.secondary_transmit}, 32'hf00, "sec");
  endtask
  task automatic s_stat;
    MDL.put(3, 4'ha, 1'h0);
    MDL.put(8, 4'h0, 1'h1);
    repeat (8) @(posedge aclk);
    wr(`MCS_OFS_CTRL, 32'h3, `MCS_RESP_OKAY);
    chk(`MCS_OFS_LINE, 32'ha03, `MCS_RESP_OKAY);
    wr(`MCS_OFS_CTRL, 32'h8, `MCS_RESP_OKAY);
    chk(`MCS_OFS_LINE, 32'h108, `MCS_RESP_OKAY);
    chk(`MCS_OFS_CTRL, 32'h8, `MCS_RESP_OKAY);
  endtask
  task automatic s_scan;
    wr(`MCS_OFS_CTRL, 32'h60, `MCS_RESP_OKAY);
    poll(32'he3);
    cmp({31'h0, irq}, 32'h1, "irq");
    repeat (20) @(posedge aclk);
    chk(`MCS_OFS_CTRL, 32'he3, `MCS_RESP_OKAY);
    wr(`MCS_OFS_CTRL, 32'h63, `MCS_RESP_OKAY);
    cmp({31'h0, irq}, 32'h0, "irq clear");
    repeat (200) @(posedge aclk);
    rd(`MCS_OFS_CTRL);
    cmp(got & 32'he0, 32'h60, "no rehalt");
    MDL.put(5, 4'h1, 1'h0);
    poll(32'he5);
    cmp({31'h0, irq}, 32'h1, "irq again");
    wr(`MCS_OFS_CTRL, 32'h25, `MCS_RESP_OKAY);
    MDL.put(7, 4'h4, 1'h0);
    poll(32'ha7);
    cmp({31'h0, irq}, 32'h0, "irq masked");
  endtask
  //////////////////////////////
  initial begin
    #500000;
    err_count++;
    results();
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    s_regs();
    s_lines();
    s_stat();
    s_scan();
    results();
  end
endmodule
